// file: hdl/ppp_top.sv
// high-voltage parallel programming port: command, address, data and readback
//==========================================================================
// Behaviour
// RL1: eeprom write fills page buffer by page latch
// RL2: write strobe with select 00 commits page
// RL3: flash read loads command then address bytes
// RL4: flash read gives low or high byte
// RL5: eeprom read presents addressed byte
// RL6: fuse write: zero programs, one erases
// RL7: byte select picks low, high, extended fuse
// RL8: fuse or lock write holds busy low
// RL9: lock write: zero programs the lock bit
// RL10: lock mode 3 protects boot lock bits
// RL11: only chip erase unprograms lock bits
// RL12: fuse and lock readback by byte select
// RL13: signature read by low address 0 to 2
// RL14: select one at address 0 gives calibration
// RL15: writes keep busy 3.7 to 4.5 ms
// RL16: chip erase keeps busy 7.5 to 9 ms
// RL17: busy low within 1 us of strobe
// RL18: bus driven only while output enable low
// RL19: action select decides what load captures
// RL20: byte select places the address byte
// RL21: command and address kept between operations
// RL22: unknown command is a no operation
`timescale 1ns/10ps
`default_nettype none
`include "ppp_map.svh"
module ppp_top #(
    parameter int WRITE_CYCLES = (`PPP_T_WRITE_MIN_NS + `PPP_CLK_NS - 1) / `PPP_CLK_NS,
    parameter int ERASE_CYCLES = (`PPP_T_ERASE_MIN_NS + `PPP_CLK_NS - 1) / `PPP_CLK_NS,
    parameter logic [7:0] SIG_BYTE0 = 8'h5A, // arbitrary value
    parameter logic [7:0] SIG_BYTE1 = 8'hA5, // arbitrary value
    parameter logic [7:0] SIG_BYTE2 = 8'h3C // arbitrary value
) (
    input wire logic REF_CLK_I,
    input wire logic RESETN_I,
    input wire logic CLK_EN_I,
    input wire logic [7:0] DATA_I,
    output logic [7:0] DATA_O,
    output logic DATA_OE_O,
    input wire logic ACTION_SELECT_HIGH_I,
    input wire logic ACTION_SELECT_LOW_I,
    input wire logic BYTE_SELECT_HIGH_I,
    input wire logic BYTE_SELECT_LOW_I,
    input wire logic LOAD_STROBE_PIN_I,
    input wire logic PAGE_LATCH_STROBE_I,
    input wire logic WRITE_N_I,
    input wire logic OUT_EN_N_I,
    input wire logic [7:0] OSC_CAL_I,
    input wire logic [15:0] FLASH_RDATA_I,
    output logic [`PPP_FLASH_AW-1:0] FLASH_ADDR_O,
    output logic READY_BUSY_FLAG_O,
    output logic [7:0] FUSE_LOW_O,
    output logic [7:0] FUSE_HIGH_O,
    output logic [7:0] FUSE_EXT_O,
    output logic [7:0] LOCK_BITS_O
);
    //======================================================================
    // pin synchronisation and edge detection
    logic [15:0] pins_s;
    logic [7:0] data_s;
    logic [1:0] act_s;
    logic [1:0] bs_s;
    logic load_s;
    logic page_latch_strobe_s;
    logic wr_n_s;
    logic oe_n_s;
    logic load_prev_q;
    logic page_latch_strobe_prev_q;
    logic wr_prev_q;
    logic load_rise;
    logic page_latch_strobe_rise;
    logic wr_fall;

    ppp_sync #(.W(16), .RST_VAL(`PPP_PIN_IDLE)) u_sync (
        .clk_i(REF_CLK_I),
        .rst_n_i(RESETN_I),
        .en_i(CLK_EN_I),
        .d_i({WRITE_N_I, OUT_EN_N_I, ACTION_SELECT_HIGH_I, ACTION_SELECT_LOW_I,
              BYTE_SELECT_HIGH_I, BYTE_SELECT_LOW_I, LOAD_STROBE_PIN_I,
              PAGE_LATCH_STROBE_I, DATA_I}),
        .q_o(pins_s)
    );
    assign {wr_n_s, oe_n_s, act_s, bs_s, load_s, page_latch_strobe_s, data_s} = pins_s;

    // previous strobe levels, idle values after reset
    always_ff @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            load_prev_q <= 1'b0;
            page_latch_strobe_prev_q <= 1'b0;
            wr_prev_q <= 1'b1;
        end else if (CLK_EN_I) begin
            load_prev_q <= load_s;
            page_latch_strobe_prev_q <= page_latch_strobe_s;
            wr_prev_q <= wr_n_s;
        end
    end
    assign load_rise = CLK_EN_I && load_s && !load_prev_q;
    assign page_latch_strobe_rise = CLK_EN_I && page_latch_strobe_s && !page_latch_strobe_prev_q;
    assign wr_fall = CLK_EN_I && wr_prev_q && !wr_n_s;

    //======================================================================
    // command decode
    function automatic ppp_pkg::ppp_cmd_e decode_cmd(input logic [7:0] b);
        ppp_pkg::ppp_cmd_e c;
        c = ppp_pkg::PPP_NOP;
        unique case (b)
            `PPP_CMD_ERASE: c = ppp_pkg::PPP_ERASE;
            `PPP_CMD_WR_FUSE: c = ppp_pkg::PPP_WR_FUSE;
            `PPP_CMD_WR_LOCK: c = ppp_pkg::PPP_WR_LOCK;
            `PPP_CMD_WR_FLASH: c = ppp_pkg::PPP_WR_FLASH;
            `PPP_CMD_WR_EE: c = ppp_pkg::PPP_WR_EE;
            `PPP_CMD_RD_SIG: c = ppp_pkg::PPP_RD_SIG;
            `PPP_CMD_RD_FUSE: c = ppp_pkg::PPP_RD_FUSE;
            `PPP_CMD_RD_FLASH: c = ppp_pkg::PPP_RD_FLASH;
            `PPP_CMD_RD_EE: c = ppp_pkg::PPP_RD_EE;
            default: c = ppp_pkg::PPP_NOP; // unknown byte becomes no operation
        endcase
        return c;
    endfunction

    //======================================================================
    // command, address and data latches; held until overwritten
    ppp_pkg::ppp_cmd_e cmd_q;
    logic [23:0] addr_q;
    logic [7:0] dlo_q;
    logic [7:0] dhi_q;

    always_ff @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            cmd_q <= ppp_pkg::PPP_NOP;
        end else if (load_rise && act_s == `PPP_ACT_CMD) begin
            cmd_q <= decode_cmd(data_s); // RL19 RL22
        end
    end

    // address bytes placed by the byte select pair; 11 leaves all alone
    always_ff @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            addr_q <= '0;
        end else if (load_rise && act_s == `PPP_ACT_ADDR) begin
            unique case (bs_s) // RL20 RL21
                `PPP_BS_00: addr_q[7:0] <= data_s;
                `PPP_BS_01: addr_q[15:8] <= data_s;
                `PPP_BS_10: addr_q[23:16] <= data_s;
                `PPP_BS_11: addr_q <= addr_q;
            endcase
        end
    end

    // data byte: the low byte select chooses the flash high byte
    always_ff @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            dlo_q <= '0;
            dhi_q <= '0;
        end else if (load_rise && act_s == `PPP_ACT_DATA) begin
            if (bs_s[0]) begin
                dhi_q <= data_s;
            end else begin
                dlo_q <= data_s; // RL1 RL6 RL9
            end
        end
    end

    //======================================================================
    // self-timed operations
    logic is_write;
    logic busy;
    logic start;
    logic ee_commit;
    logic fuse_go;
    logic lock_go;
    logic erase_go;
    logic [`PPP_TMR_W-1:0] tmr_len;

    // an unknown command never starts anything, nor does a strobe while busy
    assign is_write = cmd_q inside {ppp_pkg::PPP_ERASE, ppp_pkg::PPP_WR_FUSE, ppp_pkg::PPP_WR_LOCK,
                                    ppp_pkg::PPP_WR_FLASH, ppp_pkg::PPP_WR_EE}; // RL22
    assign start = wr_fall && is_write && !busy // RL8 RL17
                   && !(cmd_q == ppp_pkg::PPP_WR_EE && bs_s != `PPP_BS_00); // RL2
    assign ee_commit = start && cmd_q == ppp_pkg::PPP_WR_EE && bs_s == `PPP_BS_00; // RL2
    assign fuse_go = start && cmd_q == ppp_pkg::PPP_WR_FUSE;
    assign lock_go = start && cmd_q == ppp_pkg::PPP_WR_LOCK;
    assign erase_go = start && cmd_q == ppp_pkg::PPP_ERASE;
    assign tmr_len = (cmd_q == ppp_pkg::PPP_ERASE) ? ERASE_CYCLES[`PPP_TMR_W-1:0]
                                                   : WRITE_CYCLES[`PPP_TMR_W-1:0]; // RL15 RL16

    ppp_timer u_timer (
        .clk_i(REF_CLK_I),
        .rst_n_i(RESETN_I),
        .en_i(CLK_EN_I),
        .start_i(start),
        .cycles_i(tmr_len),
        .busy_o(busy)
    );

    // ready is registered; it falls the cycle after the strobe edge is seen
    always_ff @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            READY_BUSY_FLAG_O <= 1'b1;
        end else if (CLK_EN_I) begin
            READY_BUSY_FLAG_O <= !(busy || start); // RL2 RL8 RL17
        end
    end

    //======================================================================
    // eeprom page buffer and array
    logic [7:0] ee_buf [0:`PPP_EE_PAGE-1];
    logic [`PPP_EE_PAGE-1:0] ee_vld_q;
    logic [7:0] ee_mem [0:`PPP_EE_SIZE-1];

    // page latch stores the data byte at the word of the low address
    always_ff @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            ee_vld_q <= '0;
        end else if (ee_commit) begin
            ee_vld_q <= '0;
        end else if (page_latch_strobe_rise && cmd_q == ppp_pkg::PPP_WR_EE) begin
            ee_buf[addr_q[`PPP_EE_PW-1:0]] <= dlo_q; // RL1
            ee_vld_q[addr_q[`PPP_EE_PW-1:0]] <= 1'b1;
        end
    end

    // only latched bytes are written; erase fills the array with ones
    always_ff @(posedge REF_CLK_I) begin
        if (erase_go) begin
            for (int i = 0; i < `PPP_EE_SIZE; i++) begin
                ee_mem[i] <= `PPP_ERASED_BYTE;
            end
        end else if (ee_commit) begin
            for (int i = 0; i < `PPP_EE_PAGE; i++) begin
                if (ee_vld_q[i]) begin
                    ee_mem[{addr_q[`PPP_EE_AW-1:`PPP_EE_PW], i[`PPP_EE_PW-1:0]}] <= ee_buf[i]; // RL2
                end
            end
        end
    end

    //======================================================================
    // fuse and lock bytes
    logic lock_mode3;
    logic [7:0] lock_next;
    assign lock_mode3 = (LOCK_BITS_O[`PPP_LOCK_MODE_LSB+1:`PPP_LOCK_MODE_LSB] == 2'h0); // RL10
    // a write can only program (clear) lock bits; boot bits frozen in mode 3
    always_comb begin
        lock_next = LOCK_BITS_O & dlo_q; // RL9 RL11
        if (lock_mode3) begin
            lock_next[`PPP_LOCK_BOOT_MSB:`PPP_LOCK_BOOT_LSB] =
                LOCK_BITS_O[`PPP_LOCK_BOOT_MSB:`PPP_LOCK_BOOT_LSB]; // RL10
        end
    end

    // fuse byte chosen by the select pair at the strobe; 11 writes nothing
    always_ff @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            FUSE_LOW_O <= `PPP_ERASED_BYTE;
            FUSE_HIGH_O <= `PPP_ERASED_BYTE;
            FUSE_EXT_O <= `PPP_ERASED_BYTE;
        end else if (fuse_go) begin
            unique case (bs_s) // RL6 RL7
                `PPP_BS_00: FUSE_LOW_O <= dlo_q;
                `PPP_BS_01: FUSE_HIGH_O <= dlo_q;
                `PPP_BS_10: FUSE_EXT_O <= dlo_q;
                `PPP_BS_11: FUSE_EXT_O <= FUSE_EXT_O;
            endcase
        end
    end

    // lock bits return to ones only through chip erase or reset
    always_ff @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            LOCK_BITS_O <= `PPP_ERASED_BYTE;
        end else if (erase_go) begin
            LOCK_BITS_O <= `PPP_ERASED_BYTE; // RL11
        end else if (lock_go) begin
            LOCK_BITS_O <= lock_next;
        end
    end

    //======================================================================
    // readback path
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = '0;
        unique case (cmd_q)
            ppp_pkg::PPP_RD_FLASH: rd_byte = bs_s[0] ? FLASH_RDATA_I[15:8] : FLASH_RDATA_I[7:0]; // RL4
            ppp_pkg::PPP_RD_EE: rd_byte = ee_mem[addr_q[`PPP_EE_AW-1:0]]; // RL5
            ppp_pkg::PPP_RD_FUSE: begin
                unique case (bs_s) // RL12
                    `PPP_BS_00: rd_byte = FUSE_LOW_O;
                    `PPP_BS_11: rd_byte = FUSE_HIGH_O;
                    `PPP_BS_10: rd_byte = FUSE_EXT_O;
                    `PPP_BS_01: rd_byte = LOCK_BITS_O;
                endcase
            end
            ppp_pkg::PPP_RD_SIG: begin
                if (bs_s[0]) begin
                    rd_byte = (addr_q[7:0] == 8'h00) ? OSC_CAL_I : 8'h00; // RL14
                end else if (addr_q[7:0] == 8'h00) begin
                    rd_byte = SIG_BYTE0; // RL13
                end else if (addr_q[7:0] == 8'h01) begin
                    rd_byte = SIG_BYTE1;
                end else if (addr_q[7:0] == 8'h02) begin
                    rd_byte = SIG_BYTE2;
                end
            end
            default: rd_byte = 8'h00; // write commands and no operation read zero
        endcase
    end

    // data and enable registered; release lands within a few cycles of the pin
    always_ff @(posedge REF_CLK_I) begin
        if (!RESETN_I) begin
            DATA_O <= '0;
            DATA_OE_O <= 1'b0;
            FLASH_ADDR_O <= '0;
        end else if (CLK_EN_I) begin
            DATA_OE_O <= !oe_n_s; // RL18
            DATA_O <= rd_byte;
            FLASH_ADDR_O <= addr_q[`PPP_FLASH_AW-1:0]; // RL3
        end
    end

    //======================================================================
    // checks
    chk_busy_fall: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I) // RL17
        start |=> !READY_BUSY_FLAG_O)
        else $error("ready did not fall after a write start");

    chk_bus_release: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I) // RL18
        CLK_EN_I && oe_n_s |=> !DATA_OE_O)
        else $error("data bus still driven after output enable rose");

    chk_bus_drive: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I) // RL18
        DATA_OE_O |-> $past(!oe_n_s))
        else $error("data bus driven without output enable");

    chk_lock_monotone: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I) // RL11
        (LOCK_BITS_O & ~$past(LOCK_BITS_O)) != 8'h00 |-> $past(erase_go))
        else $error("lock bit unprogrammed without chip erase");

    chk_boot_lock: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I) // RL10
        lock_go && lock_mode3 |=> $stable(LOCK_BITS_O[`PPP_LOCK_BOOT_MSB:`PPP_LOCK_BOOT_LSB]))
        else $error("boot lock bits changed in lock mode 3");

    chk_cmd_capture: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I) // RL19
        load_rise && act_s == `PPP_ACT_CMD |=> cmd_q == decode_cmd($past(data_s)))
        else $error("command byte not captured");

    chk_addr_high: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I) // RL20
        load_rise && act_s == `PPP_ACT_ADDR && bs_s == `PPP_BS_01
        |=> addr_q[15:8] == $past(data_s) && $stable(addr_q[7:0]))
        else $error("address high byte misplaced");

    chk_nop_ignored: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I) // RL22
        wr_fall && cmd_q == ppp_pkg::PPP_NOP && !busy |=> READY_BUSY_FLAG_O [*2])
        else $error("write strobe acted under no operation");

    chk_fuse_high: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I) // RL7
        fuse_go && bs_s == `PPP_BS_01 |=> FUSE_HIGH_O == $past(dlo_q) && $stable(FUSE_LOW_O))
        else $error("high fuse byte not written");
endmodule
`default_nettype wire

// file: hdl/ppp_map.svh
// constants of the parallel programming port: codes, field positions, timing
`ifndef PPP_MAP_SVH
`define PPP_MAP_SVH
// command bytes
`define PPP_CMD_ERASE 8'h80
`define PPP_CMD_WR_FUSE 8'h40
`define PPP_CMD_WR_LOCK 8'h20
`define PPP_CMD_WR_FLASH 8'h10
`define PPP_CMD_WR_EE 8'h11
`define PPP_CMD_RD_SIG 8'h08
`define PPP_CMD_RD_FUSE 8'h04
`define PPP_CMD_RD_FLASH 8'h02
`define PPP_CMD_RD_EE 8'h03
// action select codes {high, low}
`define PPP_ACT_ADDR 2'h0
`define PPP_ACT_DATA 2'h1
`define PPP_ACT_CMD 2'h2
// byte select codes {high, low}
`define PPP_BS_00 2'h0
`define PPP_BS_01 2'h1
`define PPP_BS_10 2'h2
`define PPP_BS_11 2'h3
// eeprom geometry: 8 byte pages, 4K bytes
`define PPP_EE_AW 12
`define PPP_EE_PW 3
`define PPP_EE_PAGE 8
`define PPP_EE_SIZE 4096
`define PPP_FLASH_AW 17
// lock byte fields
`define PPP_LOCK_MODE_LSB 0
`define PPP_LOCK_BOOT_LSB 2
`define PPP_LOCK_BOOT_MSB 5
// reset values (erased state is all ones)
`define PPP_ERASED_BYTE 8'hFF
`define PPP_PIN_IDLE 16'hF000
// timing in ns and clock period in ns
`define PPP_CLK_NS 20
`define PPP_T_WRITE_MIN_NS 3700000
`define PPP_T_ERASE_MIN_NS 7500000
`define PPP_TMR_W 19
`endif

// file: hdl/ppp_pkg.sv
// types shared by the parallel programming port
package ppp_pkg;
    typedef enum logic [3:0] {
        PPP_NOP, PPP_ERASE, PPP_WR_FUSE, PPP_WR_LOCK, PPP_WR_FLASH,
        PPP_WR_EE, PPP_RD_SIG, PPP_RD_FUSE, PPP_RD_FLASH, PPP_RD_EE
    } ppp_cmd_e;
endpackage

// file: hdl/ppp_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none
module ppp_sync #(
    parameter int W = 16,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    // first stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_q <= RST_VAL;
            q_o <= RST_VAL;
        end else if (en_i) begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule
`default_nettype wire

// file: hdl/ppp_timer.sv
// self-timed busy counter for write and erase operations
`timescale 1ns/10ps
`default_nettype none
`include "ppp_map.svh"
module ppp_timer (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic start_i,
    input wire logic [`PPP_TMR_W-1:0] cycles_i,
    output logic busy_o
);
    logic [`PPP_TMR_W-1:0] cnt_q;
    // count down the loaded length; busy while non-zero
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
        end else if (en_i) begin
            if (start_i && cnt_q == '0) begin
                cnt_q <= cycles_i;
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
    assign busy_o = (cnt_q != '0);

    chk_busy_load: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL15
        en_i && start_i && !busy_o |=> cnt_q == $past(cycles_i))
        else $error("busy counter did not load its length");
endmodule
`default_nettype wire

// file: tb/ppp_prog_model.sv
// programmer model: drives the control pins and the data bus of the programming port
`timescale 1ns/10ps
`default_nettype none
module ppp_prog_model (
    input wire logic clk_i,
    input wire logic [7:0] bus_i,
    output logic [1:0] act_o,
    output logic [1:0] bs_o,
    output logic [7:0] data_o,
    output logic load_o,
    output logic page_latch_strobe_o,
    output logic wr_n_o,
    output logic oe_n_o
);
    //==========================================================================
    // pin sequencing
    // each level is held at least 3 cycles: the device sees pins only through a 2-stage sync
    initial begin
        act_o = 2'h3;
        bs_o = 2'h0;
        data_o = 8'hFF;
        load_o = 1'b0;
        page_latch_strobe_o = 1'b0;
        wr_n_o = 1'b1;
        oe_n_o = 1'b1;
    end

    task automatic step(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // selects and data stay put from before the rising strobe until after it falls
    task automatic load(input logic [1:0] act, input logic [1:0] bs, input logic [7:0] d);
        act_o = act;
        bs_o = bs;
        data_o = d;
        step(3);
        load_o = 1'b1;
        step(3);
        load_o = 1'b0;
        step(3);
    endtask

    task automatic cmd(input logic [7:0] d);
        load(2'h2, 2'h0, d);
    endtask

    task automatic addr(input logic [1:0] bs, input logic [7:0] d);
        load(2'h0, bs, d);
    endtask

    task automatic data(input logic [7:0] d);
        load(2'h1, 2'h0, d);
    endtask

    task automatic latch();
        page_latch_strobe_o = 1'b1;
        step(3);
        page_latch_strobe_o = 1'b0;
        step(3);
    endtask

    // select pair is returned to 00 afterwards
    task automatic wstrobe(input logic [1:0] bs);
        bs_o = bs;
        step(3);
        wr_n_o = 1'b0;
        step(3);
        wr_n_o = 1'b1;
        step(3);
        bs_o = 2'h0;
    endtask

    // bus released by us while reading: drive the inverse so a stale value cannot pass
    task automatic read(input logic [1:0] bs, output logic [7:0] q);
        bs_o = bs;
        data_o = ~data_o;
        oe_n_o = 1'b0;
        step(5);
        q = bus_i;
        oe_n_o = 1'b1;
        step(5);
    endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// self-checking testbench of the parallel programming port
`timescale 1ns/10ps
`default_nettype none
`include "ppp_map.svh"
module tb_top;
    localparam int WR_CYC = 20;
    localparam int ER_CYC = 40;
    localparam logic [7:0] SIG0 = 8'h5A; // arbitrary value
    localparam logic [7:0] SIG1 = 8'hA5; // arbitrary value
    localparam logic [7:0] SIG2 = 8'h3C; // arbitrary value
    logic clk;
    logic clk_en;
    logic rst_n;
    logic [7:0] osc_cal;
    logic [7:0] data_o;
    logic data_oe;
    logic [7:0] bus;
    logic [7:0] prog_data;
    logic [1:0] act;
    logic [1:0] bs;
    logic load;
    logic page_latch_strobe;
    logic wr_n;
    logic oe_n;
    logic [15:0] flash_rdata;
    logic [`PPP_FLASH_AW-1:0] flash_addr;
    logic ready;
    logic [7:0] f_lo;
    logic [7:0] f_hi;
    logic [7:0] f_ext;
    logic [7:0] lock;
    int n_errors = 0;
    int checks_done = 0;

    //==========================================================================
    // clock, bus resolution and flash array stand-in
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function automatic logic [15:0] flash_word(input logic [16:0] a);
        return {a[15:8] ^ {a[16], 7'h35}, ~a[7:0]};
    endfunction
    assign bus = data_oe ? data_o : prog_data;
    assign flash_rdata = flash_word(flash_addr);

    ppp_top #(.WRITE_CYCLES(WR_CYC), .ERASE_CYCLES(ER_CYC)) ppp_top_inst (
        .REF_CLK_I(clk), .RESETN_I(rst_n), .CLK_EN_I(clk_en), .DATA_I(bus), .DATA_O(data_o),
        .DATA_OE_O(data_oe), .ACTION_SELECT_HIGH_I(act[1]), .ACTION_SELECT_LOW_I(act[0]),
        .BYTE_SELECT_HIGH_I(bs[1]), .BYTE_SELECT_LOW_I(bs[0]), .LOAD_STROBE_PIN_I(load),
        .PAGE_LATCH_STROBE_I(page_latch_strobe), .WRITE_N_I(wr_n), .OUT_EN_N_I(oe_n), .OSC_CAL_I(osc_cal),
        .FLASH_RDATA_I(flash_rdata), .FLASH_ADDR_O(flash_addr), .READY_BUSY_FLAG_O(ready),
        .FUSE_LOW_O(f_lo), .FUSE_HIGH_O(f_hi), .FUSE_EXT_O(f_ext), .LOCK_BITS_O(lock));

    ppp_prog_model ppp_prog_model_inst (
        .clk_i(clk), .bus_i(bus), .act_o(act), .bs_o(bs), .data_o(prog_data), .load_o(load),
        .page_latch_strobe_o(page_latch_strobe), .wr_n_o(wr_n), .oe_n_o(oe_n));

    //==========================================================================
    // compare, timing of a write strobe, end of run
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // exp_low of 0 means the strobe must be refused; a busy start later than 53 cycles breaks 1 us
    task automatic commit(input logic [1:0] sel, input int exp_low);
        int t;
        int n;
        t = 0;
        n = 0;
        fork
            ppp_prog_model_inst.wstrobe(sel);
            begin
                while (ready === 1'b1 && t < 60) begin
                    @(negedge clk);
                    t++;
                end
                while (ready === 1'b0 && n < 1000) begin
                    @(negedge clk);
                    n++;
                end
            end
        join
        check("busy start", (t <= 53) || (exp_low == 0), 1'b1);
        check("busy cycles", n, (exp_low == 0) ? 0 : exp_low + 1);
        ppp_prog_model_inst.step(2);
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs well under 10000 cycles
    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end

    //==========================================================================
    // test sequence
    initial begin
        logic [7:0] ee [8];
        logic [7:0] fz [3];
        logic [7:0] lw [4];
        logic [1:0] rsel [4];
        logic [7:0] rexp [4];
        logic [7:0] q;
        logic [7:0] ah;
        logic [7:0] al;
        logic [7:0] ext;
        logic [16:0] fa;
        logic [15:0] w;
        logic [7:0] lk;
        int seed_r;
        seed_r = $urandom(32'h6b017edb);
        osc_cal = 8'($urandom);
        clk_en = 1'b1;
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        check("ready after reset", ready, 1'b1);
        check("fuses after reset", {f_lo, f_hi, f_ext, lock}, 32'hFFFFFFFF);
        check("bus idle", data_oe, 1'b0);
        end_test("reset");
        // one full page, a refused commit with select 01, then readback reusing the high address
        ah = 8'($urandom_range(15));
        al = 8'($urandom) & 8'hF8;
        ppp_prog_model_inst.cmd(8'h11);
        ppp_prog_model_inst.addr(2'h1, ah);
        for (int i = 0; i < 8; i++) begin
            ee[i] = 8'($urandom);
            ppp_prog_model_inst.addr(2'h0, al | 8'(i));
            ppp_prog_model_inst.data(ee[i]);
            ppp_prog_model_inst.latch();
        end
        commit(2'h1, 0);
        commit(2'h0, WR_CYC);
        ppp_prog_model_inst.cmd(8'h03);
        for (int i = 0; i < 8; i++) begin
            ppp_prog_model_inst.addr(2'h0, al | 8'(i));
            ppp_prog_model_inst.read(2'h0, q);
            check("eeprom byte", q, ee[i]);
        end
        end_test("eeprom");
        for (int k = 0; k < 3; k++) begin
            ext = 8'($urandom);
            fa = {ext[0], 16'($urandom)};
            ppp_prog_model_inst.cmd(8'h02);
            ppp_prog_model_inst.addr(2'h2, ext);
            ppp_prog_model_inst.addr(2'h1, fa[15:8]);
            ppp_prog_model_inst.addr(2'h0, fa[7:0]);
            check("flash address", flash_addr, fa);
            w = flash_word(fa);
            ppp_prog_model_inst.read(2'h0, q);
            check("flash low byte", q, w[7:0]);
            ppp_prog_model_inst.read(2'h1, q);
            check("flash high byte", q, w[15:8]);
            check("bus released", data_oe, 1'b0);
        end
        end_test("flash read");
        for (int i = 0; i < 3; i++) begin
            fz[i] = 8'($urandom);
            ppp_prog_model_inst.cmd(8'h40);
            ppp_prog_model_inst.data(fz[i]);
            commit(2'(i), WR_CYC);
        end
        check("fuse bytes", {f_lo, f_hi, f_ext}, {fz[0], fz[1], fz[2]});
        end_test("fuse write");
        // boot bits start unprogrammed, mode 3 is set, then an unprogram and a boot attempt
        lk = 8'hFF;
        lw = '{8'($urandom) | 8'h03, 8'hFC, 8'hFF, 8'($urandom) & 8'hC3};
        for (int i = 0; i < 4; i++) begin
            ppp_prog_model_inst.cmd(8'h20);
            ppp_prog_model_inst.data(lw[i]);
            commit(2'h0, WR_CYC);
            lk = lk & ((lk[1:0] == 2'h0) ? (lw[i] | 8'h3C) : lw[i]);
            check("lock bits", lock, lk);
        end
        end_test("lock write");
        rsel = '{2'h0, 2'h3, 2'h2, 2'h1};
        rexp = '{fz[0], fz[1], fz[2], lk};
        ppp_prog_model_inst.cmd(8'h04);
        for (int i = 0; i < 4; i++) begin
            ppp_prog_model_inst.read(rsel[i], q);
            check("fuse readback", q, rexp[i]);
        end
        end_test("fuse read");
        rexp = '{SIG0, SIG1, SIG2, osc_cal};
        ppp_prog_model_inst.cmd(8'h08);
        for (int i = 0; i < 4; i++) begin
            ppp_prog_model_inst.addr(2'h0, (i == 3) ? 8'h00 : 8'(i));
            ppp_prog_model_inst.read((i == 3) ? 2'h1 : 2'h0, q);
            check("signature", q, rexp[i]);
        end
        end_test("signature");
        clk_en = 1'b0;
        ppp_prog_model_inst.cmd(8'h40);
        clk_en = 1'b1;
        commit(2'h0, 0);
        ppp_prog_model_inst.cmd(8'h55);
        commit(2'h0, 0);
        ppp_prog_model_inst.load(2'h3, 2'h0, 8'h40);
        commit(2'h0, 0);
        check("fuses kept", {f_lo, f_hi, f_ext}, {fz[0], fz[1], fz[2]});
        end_test("no operation");
        ppp_prog_model_inst.cmd(8'h80);
        commit(2'h0, ER_CYC);
        check("lock erased", lock, 8'hFF);
        check("fuses kept", {f_lo, f_hi, f_ext}, {fz[0], fz[1], fz[2]});
        ppp_prog_model_inst.cmd(8'h03);
        ppp_prog_model_inst.addr(2'h1, ah);
        ppp_prog_model_inst.addr(2'h0, al);
        ppp_prog_model_inst.read(2'h0, q);
        check("eeprom erased", q, 8'hFF);
        end_test("chip erase");
        report_and_stop();
    end
endmodule
`default_nettype wire
